// File: qct_pkg.sv
// Constants and types for the four-channel counter/timer block.
// Assumes a single 40 MHz clock domain shared by all users of the package.
package qct_pkg;
  localparam int NUM_CH = 4;
  localparam int CNT_W = 8;
  localparam int PRE_W = 8;
  localparam int NUM_ZC = 3;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [CNT_W-1:0] TC_RST = 8'h00;
  localparam logic [PRE_W-1:0] PRESCALE_DIV = 8'h10;
  localparam logic [4:0] VEC_BASE_RST = 5'h00;
  typedef enum logic [1:0] {QCT_IDLE, QCT_WAIT, QCT_RUN} qct_state_e;
endpackage

// File: qct_channel.sv
// One counter/timer channel: mode, trigger edge, reload and zero detection.
// Assumes the trigger input is already synchronised to clock.
`timescale 1ns/100ps
`default_nettype none
module qct_channel
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic trig,
  input wire logic timer_mode,
  input wire logic rise_edge,
  input wire logic run,
  input wire logic tc_load,
  input wire logic [qct_pkg::CNT_W-1:0] tc_value,
  output logic [qct_pkg::CNT_W-1:0] count,
  output logic zero_pulse
);
  qct_pkg::qct_state_e state_q, state_d;
  logic trig_q;
  logic [qct_pkg::CNT_W-1:0] cnt_q, cnt_d, tc_q;
  logic [qct_pkg::PRE_W-1:0] pre_q, pre_d;
  logic zero_q;
  wire edge_seen = rise_edge ? (trig & ~trig_q) : (~trig & trig_q);
  wire pre_tick = (pre_q == qct_pkg::PRESCALE_DIV - 8'h01);
  // Decrement step per mode
  wire step = (state_q == qct_pkg::QCT_RUN) &&
              (timer_mode ? pre_tick : edge_seen);
  wire at_one = (cnt_q == 8'h01) || (cnt_q == 8'h00);
  wire hit_zero = step && at_one;

  // Next state and count
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    pre_d = timer_mode && state_q == qct_pkg::QCT_RUN ? pre_q + 8'h01 : 8'h00;
    if (pre_tick)
      pre_d = 8'h00;
    unique case (state_q)
      qct_pkg::QCT_IDLE: if (run) state_d = timer_mode ? qct_pkg::QCT_WAIT : qct_pkg::QCT_RUN;
      qct_pkg::QCT_WAIT: if (edge_seen) state_d = qct_pkg::QCT_RUN;
      qct_pkg::QCT_RUN: ;
    endcase
    if (step)
      cnt_d = at_one ? tc_q : cnt_q - 8'h01;
    if (!run)
      state_d = qct_pkg::QCT_IDLE;
    if (tc_load)
      cnt_d = tc_value;
  end

  // State registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_q <= qct_pkg::QCT_IDLE;
      trig_q <= 1'b0;
      cnt_q <= qct_pkg::CNT_RST;
      tc_q <= qct_pkg::TC_RST;
      pre_q <= 8'h00;
      zero_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      trig_q <= trig;
      cnt_q <= cnt_d;
      pre_q <= pre_d;
      zero_q <= hit_zero;
      if (tc_load)
        tc_q <= tc_value;
    end
  end
  assign count = cnt_q;
  assign zero_pulse = zero_q;

  property p_reload;
    @(posedge clock) disable iff (!rst_n)
    (hit_zero && !tc_load) |=> (cnt_q == $past(tc_q));
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at zero");
  property p_count_one;
    @(posedge clock) disable iff (!rst_n)
    (step && !at_one && !tc_load) |=> (cnt_q == $past(cnt_q) - 8'h01);
  endproperty
  a_count_one: assert property (p_count_one) else $error("bad decrement");
  property p_wait_edge;
    @(posedge clock) disable iff (!rst_n)
    (state_q == qct_pkg::QCT_WAIT && run && !edge_seen) |=> (state_q == qct_pkg::QCT_WAIT);
  endproperty
  a_wait_edge: assert property (p_wait_edge) else $error("timer started without edge");
  property p_zero_pulse;
    @(posedge clock) disable iff (!rst_n)
    zero_q |-> $past(hit_zero);
  endproperty
  a_zero_pulse: assert property (p_zero_pulse) else $error("spurious zero pulse");
  property p_counter_hold;
    @(posedge clock) disable iff (!rst_n)
    (!timer_mode && !edge_seen && !tc_load) |=> (cnt_q == $past(cnt_q));
  endproperty
  a_counter_hold: assert property (p_counter_hold) else $error("count moved without event");
endmodule
`default_nettype wire

// File: qct_top.sv
// Top of the four-channel counter/timer with daisy chain interrupts.
// Assumes trigger pins are asynchronous; control ports come from host logic on clock.
`timescale 1ns/100ps
`default_nettype none
module qct_top
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] trig_pin,
  input wire logic [3:0] timer_mode,
  input wire logic [3:0] rise_edge,
  input wire logic [3:0] run,
  input wire logic [3:0] irq_enable,
  input wire logic [3:0] tc_load,
  input wire logic [7:0] tc_value,
  input wire logic [1:0] read_sel,
  input wire logic [4:0] vec_base,
  input wire logic vec_load,
  input wire logic int_ack,
  input wire logic ret_done,
  input wire logic chain_in,
  output logic [7:0] read_data,
  output logic [2:0] zero_out,
  output logic int_req_n,
  output logic chain_out,
  output logic [7:0] vector,
  output logic vector_valid
);
  logic [3:0] sync1_q, sync2_q, pend_q, pend_d, serv_q, serv_d;
  logic [7:0] cnt [4];
  logic [3:0] zero;
  logic [4:0] vbase_q;
  logic [7:0] rd_q, vec_q;
  logic [2:0] zo_q;
  logic intn_q, chain_q, vv_q;

  // Channels in a generate loop
  genvar i;
  generate
    for (i = 0; i < qct_pkg::NUM_CH; i++)
    begin : g_ch
      qct_channel u_ch (.clock(clock), .rst_n(rst_n), .trig(sync2_q[i]),
        .timer_mode(timer_mode[i]), .rise_edge(rise_edge[i]), .run(run[i]),
        .tc_load(tc_load[i]), .tc_value(tc_value), .count(cnt[i]), .zero_pulse(zero[i]));
    end
  endgenerate

  // Priority: a channel may act only if no higher one is pending or in service
  wire [3:0] blk = {|(pend_q[2:0] | serv_q[2:0]), |(pend_q[1:0] | serv_q[1:0]),
                    pend_q[0] | serv_q[0], 1'b0};
  wire [3:0] win = pend_q & ~blk & ~serv_q & {4{chain_in}};
  wire [3:0] srv_hi = serv_q & ~{serv_q[2:0] & 3'h7, 1'b0} & ~{|serv_q[1:0], serv_q[0], 2'b00};
  wire [1:0] win_idx = win[0] ? 2'd0 : win[1] ? 2'd1 : win[2] ? 2'd2 : 2'd3;
  wire [3:0] win_one = 4'h1 << win_idx;
  wire ack_go = int_ack && (|win);

  // Pending and in-service update, set beats clear
  always_comb
  begin
    pend_d = pend_q;
    serv_d = serv_q;
    if (ack_go)
    begin
      pend_d = pend_q & ~win_one;
      serv_d = serv_q | win_one;
    end
    if (ret_done)
      serv_d = serv_d & ~srv_hi;
    pend_d = pend_d | (zero & irq_enable);
  end

  // Trigger pin synchroniser
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end
    else
    begin
      sync1_q <= trig_pin;
      sync2_q <= sync1_q;
    end
  end

  // Pending and in-service flags
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pend_q <= 4'h0;
      serv_q <= 4'h0;
    end
    else
    begin
      pend_q <= pend_d;
      serv_q <= serv_d;
    end
  end

  // Vector base and vector register
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      vbase_q <= qct_pkg::VEC_BASE_RST;
      vec_q <= 8'h00;
      vv_q <= 1'b0;
    end
    else
    begin
      if (vec_load)
        vbase_q <= vec_base;
      vv_q <= ack_go;
      if (ack_go)
        vec_q <= {vbase_q, win_idx, 1'b0};
    end
  end

  // Registered outputs
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rd_q <= 8'h00;
      zo_q <= 3'h0;
      intn_q <= 1'b1;
      chain_q <= 1'b0;
    end
    else
    begin
      rd_q <= cnt[read_sel];
      zo_q <= zero[2:0];
      intn_q <= ~(|win);
      chain_q <= chain_in && ~(|pend_d) && ~(|serv_d);
    end
  end
  assign read_data = rd_q;
  assign zero_out = zo_q;
  assign int_req_n = intn_q;
  assign chain_out = chain_q;
  assign vector = vec_q;
  assign vector_valid = vv_q;

  property p_vector;
    @(posedge clock) disable iff (!rst_n)
    ack_go |=> (vv_q && vector[2:1] == $past(win_idx) && vector[7:3] == $past(vbase_q));
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector");
  property p_prio;
    @(posedge clock) disable iff (!rst_n)
    (ack_go && pend_q[0] && !serv_q[0] && chain_in) |=> (vector[2:1] == 2'd0);
  endproperty
  a_prio: assert property (p_prio) else $error("channel 0 not first");
  property p_irq_set;
    @(posedge clock) disable iff (!rst_n)
    (zero[1] && irq_enable[1]) |=> pend_q[1];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt lost");
  property p_zero_out;
    @(posedge clock) disable iff (!rst_n)
    zero[0] |=> zero_out[0];
  endproperty
  a_zero_out: assert property (p_zero_out) else $error("zero output missing");
  property p_read;
    @(posedge clock) disable iff (!rst_n)
    1'b1 |=> (read_data == $past(cnt[read_sel]));
  endproperty
  a_read: assert property (p_read) else $error("readback mismatch");
  // Chain, service and request checks
  property p_chain_block;
    @(posedge clock) disable iff (!rst_n)
    !chain_in |=> int_req_n;
  endproperty
  a_chain_block: assert property (p_chain_block) else $error("request while chain low");
  property p_chain_busy;
    @(posedge clock) disable iff (!rst_n)
    ((|pend_q) || (|serv_q)) |-> !chain_out;
  endproperty
  a_chain_busy: assert property (p_chain_busy) else $error("chain passed while busy");
  property p_chain_low;
    @(posedge clock) disable iff (!rst_n)
    !chain_in |=> !chain_out;
  endproperty
  a_chain_low: assert property (p_chain_low) else $error("chain passed while closed");
  property p_ret_clear;
    @(posedge clock) disable iff (!rst_n)
    (ret_done && serv_q[0]) |=> !serv_q[0];
  endproperty
  a_ret_clear: assert property (p_ret_clear) else $error("service not ended");
  property p_ack_take;
    @(posedge clock) disable iff (!rst_n)
    (ack_go && win[0] && !zero[0]) |=> (serv_q[0] && !pend_q[0]);
  endproperty
  a_ack_take: assert property (p_ack_take) else $error("ack not taken");
  property p_vec_hold;
    @(posedge clock) disable iff (!rst_n)
    !ack_go |=> $stable(vector);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector changed without ack");
  property p_vv_src;
    @(posedge clock) disable iff (!rst_n)
    vector_valid |-> $past(ack_go);
  endproperty
  a_vv_src: assert property (p_vv_src) else $error("vector valid without ack");
  property p_req_low;
    @(posedge clock) disable iff (!rst_n)
    (|win) |=> !int_req_n;
  endproperty
  a_req_low: assert property (p_req_low) else $error("request not raised");
  property p_req_high;
    @(posedge clock) disable iff (!rst_n)
    !(|pend_q) |=> int_req_n;
  endproperty
  a_req_high: assert property (p_req_high) else $error("request with nothing pending");
  property p_pend_mask;
    @(posedge clock) disable iff (!rst_n)
    (!irq_enable[2] && !pend_q[2]) |=> !pend_q[2];
  endproperty
  a_pend_mask: assert property (p_pend_mask) else $error("masked channel pending");
  property p_zero_src;
    @(posedge clock) disable iff (!rst_n)
    zero_out[2] |-> $past(zero[2]);
  endproperty
  a_zero_src: assert property (p_zero_src) else $error("spurious zero output");
endmodule
`default_nettype wire

// File: qct_host_model.sv
// Host model: acknowledges interrupts one at a time and ends each service.
// Assumes the block samples int_ack and ret_done on rising clock edges.
`timescale 1ns/100ps
`default_nettype none
module qct_host_model
(
  input wire logic clock,
  input wire logic int_req_n,
  input wire logic [7:0] vector,
  input wire logic [3:0] slow,
  output logic int_ack,
  output logic ret_done,
  output logic [31:0] got_log
);
  // Ack, take the vector, then end service after a variable delay
  initial
  begin
    int_ack = 1'b0;
    ret_done = 1'b0;
    got_log = 32'h0;
    forever
    begin
      @(negedge clock);
      if (int_req_n === 1'b0)
      begin
        int_ack = 1'b1;
        @(negedge clock);
        int_ack = 1'b0;
        @(negedge clock);
        got_log = {got_log[23:0], vector};
        repeat (slow) @(negedge clock);
        ret_done = 1'b1;
        @(negedge clock);
        ret_done = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the four-channel counter/timer.
// Assumes the host model answers interrupts; inputs change on falling edges.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clock, rst_n, vec_load, chain_in, chain_out, int_req_n, int_ack, ret_done, vector_valid;
  logic [3:0] trig_pin, timer_mode, rise_edge, run, irq_enable, tc_load, slow;
  logic [7:0] tc_value, read_data, vector;
  logic [4:0] vec_base;
  logic [1:0] read_sel;
  logic [2:0] zero_out;
  logic [31:0] got_log;
  int fails, samples_checked, seed, n, vvc, zc[3];
  qct_top qct_top_i (.clock(clock), .rst_n(rst_n), .trig_pin(trig_pin),
    .timer_mode(timer_mode), .rise_edge(rise_edge), .run(run), .irq_enable(irq_enable),
    .tc_load(tc_load), .tc_value(tc_value), .read_sel(read_sel), .vec_base(vec_base),
    .vec_load(vec_load), .int_ack(int_ack), .ret_done(ret_done), .chain_in(chain_in),
    .read_data(read_data), .zero_out(zero_out), .int_req_n(int_req_n),
    .chain_out(chain_out), .vector(vector), .vector_valid(vector_valid));
  qct_host_model qct_host_model_i (.clock(clock), .int_req_n(int_req_n), .vector(vector),
    .slow(slow), .int_ack(int_ack), .ret_done(ret_done), .got_log(got_log));
  // Clock and zero pulse tally
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(negedge clock)
  begin
    for (int i = 0; i < 3; i++) if (zero_out[i] === 1'b1) zc[i]++;
    if (vector_valid === 1'b1) vvc++;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One active edge then back to idle
  task automatic pulse(input int ch);
    trig_pin[ch] = rise_edge[ch];
    repeat (5) @(negedge clock);
    trig_pin[ch] = ~rise_edge[ch];
    repeat (5) @(negedge clock);
  endtask
  task automatic load(input logic [3:0] m, input logic [7:0] v);
    tc_value = v;
    tc_load = m;
    @(negedge clock);
    tc_load = 4'h0;
  endtask
  function automatic logic [7:0] exp_cnt(input int tc, input int k);
    return 8'(tc - (k % tc));
  endfunction
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    print_verdict();
  end
  // Main sequence
  initial
  begin
    seed = $urandom(46);
    {trig_pin, timer_mode, rise_edge, run, irq_enable, tc_load} = 24'h0;
    {vec_load, vec_base, read_sel, tc_value, rst_n} = 0;
    slow = 4'h1;
    chain_in = 1'b1;
    zc = '{0, 0, 0};
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    check("int_req_n", int_req_n, 1);
    check("read_data", read_data, 0);
    // Counter mode, both polarities, random reload values
    for (int ch = 0; ch < 4; ch++)
    begin
      n = 2 + $urandom_range(4);
      rise_edge[ch] = ch[0];
      trig_pin[ch] = ~rise_edge[ch];
      read_sel = 2'(ch);
      repeat (5) @(negedge clock);
      load(4'h1 << ch, 8'(n));
      run[ch] = 1'b1;
      for (int k = 1; k <= n; k++)
      begin
        pulse(ch);
        check("count", read_data, exp_cnt(n, k));
      end
      if (ch < 3) check("zero_pulses", zc[ch], 1);
      run[ch] = 1'b0;
    end
    // All four reach zero together; vectors come in chain order
    vec_base = 5'($urandom);
    vec_load = 1'b1;
    slow = 4'($urandom_range(1, 9));
    @(negedge clock);
    vec_load = 1'b0;
    load(4'hf, 8'h01);
    {irq_enable, run} = 8'hff;
    repeat (4) @(negedge clock);
    trig_pin = rise_edge;
    repeat (80) @(negedge clock);
    check("vectors", got_log, {vec_base, 3'h0, vec_base, 3'h2, vec_base, 3'h4,
      vec_base, 3'h6});
    check("int_req_n", int_req_n, 1);
    check("chain_out", chain_out, 1);
    check("vector_valid", vvc, 4);
    // Chain input low holds off a pending channel until it rises again
    chain_in = 1'b0;
    trig_pin = ~rise_edge;
    {irq_enable, run} = 8'h22;
    repeat (5) @(negedge clock);
    pulse(1);
    repeat (10) @(negedge clock);
    check("int_req_n", int_req_n, 1);
    check("chain_out", chain_out, 0);
    chain_in = 1'b1;
    repeat (30) @(negedge clock);
    check("vector", got_log[7:0], {vec_base, 3'h2});
    check("vector_valid", vvc, 5);
    check("chain_out", chain_out, 1);
    // Timer waits for its edge, then counts prescaled clocks
    {irq_enable, run} = 8'h00;
    trig_pin = ~rise_edge;
    timer_mode[0] = 1'b1;
    repeat (5) @(negedge clock);
    load(4'h1, 8'h02);
    run[0] = 1'b1;
    repeat (60) @(negedge clock);
    check("timer_idle", zc[0], 2);
    pulse(0);
    repeat (40) @(negedge clock);
    check("timer_zero", zc[0], 3);
    print_verdict();
  end
endmodule
`default_nettype wire
